// [bench/apmio_cpu_model.sv]
// processor model on the stop-clock line
// assumes stopClk is a registered level on clk
`timescale 1ns/10ps
module apmio_cpu_model
(
  // clock and stop-clock
  input  wire logic clk,
  input  wire logic stopClk,
  // core halted
  output logic      halted
);
  // the core stops on the edge after it sees stop-clock
  always_ff @(posedge clk)
  begin
    halted <= stopClk;
  end
endmodule

// [bench/apmio_top_props.sv]
// port checker for apmio_top, one clock domain
// sees only top ports; bound after the module
`timescale 1ns/10ps
module apmio_top_props
  import apmio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // host cycles
  input  wire apmio_req_s  ioReq,
  input  wire logic [31:0] ioRdData,
  input  wire logic        ioRdValid,
  // strap and outputs
  input  wire logic        cfgTimer32,
  input  wire logic        stopClockOut,
  input  wire logic        supplyOnOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // decoded dword and sleep-go write
  wire       rdA = ioReq.rd;
  wire [5:0] dw  = ioReq.addr[7:2];
  wire       go  = ioReq.wr && ioReq.be[1] && ioReq.data[13] && dw == 6'h01;
  chk_read_answer: assert property (rdA |=> ioRdValid) else $error("read unanswered");
  chk_level_zero: assert property (rdA && dw == 6'h05 |=> ioRdData == 32'h0)
    else $error("level port data");
  chk_level3_stop: assert property (rdA && dw == 6'h05 && ioReq.be[1]
    |-> ##2 stopClockOut) else $error("no stop after level3");
  chk_sleep_go: assert property (rdA && dw == 6'h01 |=> !ioRdData[13])
    else $error("sleep go reads one");
  chk_upper_byte: assert property (rdA && dw == 6'h02 && !cfgTimer32
    |=> ioRdData[31:24] == 8'h00) else $error("upper byte set");
  chk_thr_resv: assert property (rdA && dw == 6'h04
    |=> ioRdData[31:5] == 27'h0 && !ioRdData[0]) else $error("throttle reserved");
  chk_stat_resv: assert property (rdA && dw == 6'h00
    |=> (ioRdData[15:0] & ~MASK_PM_STATUS) == 16'h0) else $error("status reserved");
  chk_soft_off: assert property (go && ioReq.data[12:10] == 3'h0 |-> ##2 !supplyOnOut)
    else $error("soft off missed");
  chk_suspend_c3: assert property (go && ioReq.data[12:10] == 3'h2
    |-> ##2 stopClockOut && supplyOnOut) else $error("suspend missed");
endmodule
bind apmio_top apmio_top_props u_props (.clk(clk), .rst_n(rst_n), .ioReq(ioReq),
  .ioRdData(ioRdData), .ioRdValid(ioRdValid), .cfgTimer32(cfgTimer32),
  .stopClockOut(stopClockOut), .supplyOnOut(supplyOnOut));

// [bench/testbench.sv]
// self-checking bench for apmio_top
// host i/o tasks, board events, cpu model on stop-clock
`timescale 1ns/10ps
module testbench;
  import apmio_pkg::*;
  // bench signals
  logic        clk, rst_n, refClk, btn, bmReq, alarm, sci, smi, stopClk, supplyOn, halted;
  apmio_req_s  ioReq;
  logic [31:0] ioRdData, rdv, t0;
  logic        ioRdValid;
  logic        ring, thrSlow;   // ring input and throttle time base strap
  logic [7:0]  ext;
  int          miscompares, checks;
  // short override and slot counts keep the run brief
  apmio_top #(.OVERRIDE_CYCLES(20), .SLOW_TICK_CYCLES(16)) u_dut (.clk(clk), .rst_n(rst_n),
    .ioReq(ioReq), .ioRdData(ioRdData), .ioRdValid(ioRdValid), .refClkIn(refClk),
    .powerButtonIn(btn), .busMasterReqIn(bmReq), .alarmEventIn(alarm), .globalEventIn(1'b0),
    .ringIn(ring), .serialBusEventIn(1'b0), .extEventIn(ext), .cfgTimer32(1'b0),
    .cfgThrottleSlow(thrSlow), .sciOut(sci), .smiOut(smi), .stopClockOut(stopClk),
    .supplyOnOut(supplyOn));
  apmio_cpu_model u_cpu (.clk(clk), .stopClk(stopClk), .halted(halted));
  // 100 MHz system clock and a free 14.3 MHz reference
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    refClk = 0;
    // offset keeps reference edges away from the sampling edge of clk
    #1;
    forever #35 refClk = ~refClk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one host cycle; read data stands one cycle, so take it right after the answer edge
  task automatic io(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    ioReq = '{rd: !w, wr: w, addr: a, be: b, data: d};
    tick(1);
    rdv = ioRdData;
    ioReq.rd = 0;
    ioReq.wr = 0;
    tick(1);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_timer();
    io(0, 8'h08, 4'hf, 0);
    t0 = rdv;
    chk(t0 < 2, 1);
    tick(100);
    io(1, 8'h08, 4'hf, 0);
    io(0, 8'h08, 4'hf, 0);
    chk(rdv > t0, 1);
    chk(rdv[31:24], 0);
  endtask
  task automatic t_status();
    alarm = 1;
    tick(3);
    for (int k = 0; k < 2; k++)
    begin
      io(1, 8'h00, 4'h3, k ? 32'h0400 : 32'h0);
      io(0, 8'h00, 4'h3, 0);
      chk(rdv & 32'h0400, k ? 0 : 32'h0400);
    end
    alarm = 0;
  endtask
  // level-2 left by a bus master; level-3 only when busmaster_wake allows
  task automatic t_cpu();
    int n;
    io(0, 8'h14, 4'h1, 0);
    chk(rdv, 0);
    tick(2);
    chk(halted, 1);
    bmReq = 1;
    tick(4);
    chk(stopClk, 0);
    bmReq = 0;
    for (int k = 0; k < 2; k++)
    begin
      io(1, 8'h04, 4'h1, k ? 32'h2 : 32'h0);
      io(0, 8'h15, 4'h2, 0);
      chk(rdv, 0);
      tick(2);
      chk(halted, 1);
      bmReq = 1;
      tick(4);
      chk(stopClk, !k);
      bmReq = 0;
    end
    // throttled level-2: duty 001 stops at most one eighth of 256 cycles
    io(1, 8'h10, 4'h1, 32'h12);
    io(0, 8'h14, 4'h1, 0);
    n = 0;
    repeat (256)
    begin
      tick(1);
      n += stopClk;
    end
    chk(n > 0 && n <= 32, 1);
    bmReq = 1;
    tick(2);
    bmReq = 0;
  endtask
  task automatic t_release();
    io(1, 8'h28, 4'hc, 32'h0020_0000);
    io(1, 8'h04, 4'h1, 32'h4);
    tick(3);
    chk(smi, 1);
    io(1, 8'h28, 4'h1, 32'h20);
    io(0, 8'h04, 4'h1, 0);
    chk(rdv & 32'h4, 0);
  endtask
  task automatic t_gp();
    io(1, 8'h20, 4'hc, 32'h0001_0000);
    ext = 8'h01;
    tick(3);
    chk({sci, smi}, 2'b10);
    io(1, 8'h24, 4'h3, 32'h1);
    tick(2);
    chk(smi, 1);
    io(1, 8'h20, 4'h3, 32'h1);
    tick(2);
    chk({sci, smi}, 2'b00);
    ext = 0;
  endtask
  // reserved kind does not sleep; soft off and suspend, each woken by the alarm
  task automatic t_sleep();
    io(1, 8'h24, 4'hc, 32'h0100_0000);
    io(1, 8'h04, 4'h2, 32'h2400);
    tick(2);
    chk({supplyOn, stopClk}, 2'b10);
    for (int k = 0; k < 2; k++)
    begin
      io(1, 8'h04, 4'h2, k ? 32'h2800 : 32'h2000);
      tick(2);
      chk({supplyOn, stopClk}, k ? 2'b11 : 2'b00);
      alarm = 1;
      tick(3);
      chk({supplyOn, stopClk}, 2'b10);
      io(0, 8'h00, 4'h3, 0);
      chk(rdv & 32'h8000, 32'h8000);
      io(1, 8'h00, 4'h3, 32'hffff);
      alarm = 0;
    end
  endtask
  task automatic t_button();
    btn = 1;
    tick(30);
    btn = 0;
    chk(supplyOn, 0);
    io(0, 8'h00, 4'h3, 0);
    chk(rdv & 32'h0900, 32'h0800);
    // ring with its supply control set brings the supply back
    io(1, 8'h24, 4'hc, 32'h0400_0000);
    ring = 1;
    tick(3);
    chk(supplyOn, 1);
    ring = 0;
  endtask
  initial
  begin
    {btn, bmReq, alarm, ring, ext, rst_n} = '0;
    thrSlow = 1;
    ioReq = '0;
    miscompares = 0;
    checks = 0;
    tick(8);
    rst_n = 1;
    tick(3);
    t_timer();
    t_status();
    t_cpu();
    t_release();
    t_gp();
    t_sleep();
    t_button();
    print_verdict();
  end
  // a hang counts as a mismatch
  initial
  begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule

// [logic/apmio_pkg.sv]
// power management i/o block: register map, field positions, reset values,
// timing counts, state enums and the host access carrier.
// assumes a 100 MHz system clock and byte-lane host i/o cycles.
package apmio_pkg;

  // byte offsets of the host visible registers
  localparam logic [7:0] OFS_PM_STATUS  = 8'h00;
  localparam logic [7:0] OFS_PM_ENABLE  = 8'h02;
  localparam logic [7:0] OFS_PM_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TIMER      = 8'h08;
  localparam logic [7:0] OFS_CPU_CTL    = 8'h10;
  localparam logic [7:0] OFS_LEVEL2     = 8'h14;
  localparam logic [7:0] OFS_LEVEL3     = 8'h15;
  localparam logic [7:0] OFS_GP_STATUS  = 8'h20;
  localparam logic [7:0] OFS_GP_INTERRUPT_SELECT  = 8'h22;
  localparam logic [7:0] OFS_GP_SMI_EN  = 8'h24;
  localparam logic [7:0] OFS_SUPPLY     = 8'h26;
  localparam logic [7:0] OFS_GLB_STATUS = 8'h28;
  localparam logic [7:0] OFS_GLB_ENABLE = 8'h2a;

  // event status / enable bit positions
  localparam int WAKE_BIT   = 15;
  localparam int OVR_BIT    = 11;
  localparam int ALARM_BIT  = 10;
  localparam int PRESS_BIT  = 8;
  localparam int GLOBAL_BIT = 5;
  localparam int BUSM_BIT   = 4;
  localparam int TIMER_BIT  = 0;
  // sleep control fields
  localparam int SLEEP_GO_BIT = 13;
  localparam int KIND_LSB     = 10;
  localparam int GREL_BIT     = 2;
  localparam int BMWAKE_BIT   = 1;
  localparam int SELECT_BIT   = 0;
  // throttle control fields
  localparam int THR_EN_BIT   = 4;
  localparam int DUTY_LSB     = 1;
  // firmware flag / enable position in the global pair
  localparam int FW_BIT       = 5;
  // supply resume control positions
  localparam int RING_CTL_BIT = 10;
  localparam int BTN_CTL_BIT  = 9;
  localparam int ALM_CTL_BIT  = 8;
  localparam int EXT0_CTL_BIT = 0;
  // general status positions
  localparam int SBUS_BIT     = 9;
  localparam int RING_BIT     = 8;

  // implemented-bit masks, everything else is reserved; MASK_ROUTED picks the select-routed events
  localparam logic [15:0] MASK_PM_STATUS = 16'h8d31;
  localparam logic [15:0] MASK_PM_ENABLE = 16'h0521;
  localparam logic [15:0] MASK_PM_CTL    = 16'h1c07;
  localparam logic [15:0] MASK_ROUTED    = 16'h0510;
  localparam logic [31:0] MASK_CPU_CTL   = 32'h0000001e;
  localparam logic [15:0] MASK_GP_STATUS = 16'h03ff;
  localparam logic [15:0] MASK_GP_SCI    = 16'h0003;
  localparam logic [15:0] MASK_GP_SMI    = 16'h03ff;
  localparam logic [15:0] MASK_SUPPLY    = 16'h0701;
  localparam logic [15:0] MASK_GLB       = 16'h0020;

  // reset values
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // sleep kind codes
  localparam logic [2:0] KIND_SOFT_OFF = 3'h0;
  localparam logic [2:0] KIND_SUSPEND  = 3'h2;

  // timing: 100 MHz clock
  localparam int CLK_MHZ        = 100;
  localparam int OVERRIDE_S     = 4;
  localparam int OVERRIDE_CYC   = OVERRIDE_S * CLK_MHZ * 1000000;
  localparam int THR_FAST_US    = 32;
  localparam int THR_FAST_CYC   = THR_FAST_US * CLK_MHZ;
  localparam int THR_SLOW_MS    = 1;
  localparam int THR_SLOW_CYC   = THR_SLOW_MS * CLK_MHZ * 1000;
  localparam logic [1:0] REF_DIV_LAST = 2'h3;

  // system sleep state
  typedef enum logic [1:0] {
    SLP_WORK = 2'b00,
    SLP_OFF  = 2'b01,
    SLP_SUSP = 2'b10
  } apmio_sleep_e;

  // processor clock state
  typedef enum logic [1:0] {
    CPU_C0 = 2'b00,
    CPU_C2 = 2'b01,
    CPU_C3 = 2'b10
  } apmio_cpu_e;

  // one host i/o cycle, dword aligned with byte lanes
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] data;
  } apmio_req_s;

endpackage

// [logic/apmio_timer.sv]
// power management timer; counts only while run is high, else holds.
// assumes refClkIn is the 14.31818 MHz reference sampled on clk.
`timescale 1ns/10ps
module apmio_timer
  import apmio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstN,
  // reference and control
  input  wire logic        refClkIn,
  input  wire logic        run,
  input  wire logic        cfgTimer32,
  // results
  output logic [31:0]      count,
  output logic             msbEvent
);

  logic        refPrev;   // last sampled reference level
  logic [1:0]  divCnt;    // divide by four gives 3.58 MHz
  logic [31:0] cnt;       // raw count, always 32 bits wide

  // a stopped reference gives no edges, so the count simply holds
  wire refRise = run & refClkIn & ~refPrev;
  wire tick    = refRise & (divCnt == REF_DIV_LAST);
  wire [31:0] cntNext = cnt + 32'h1;
  // the flag pulses when the top bit of the selected width changes
  wire msbFlip = tick & (cfgTimer32 ? (cntNext[31] ^ cnt[31])
                                    : (cntNext[23] ^ cnt[23]));

  // reference edge tracking and divider
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      refPrev <= 1'b0;
      divCnt  <= 2'h0;
    end
    else
    begin
      refPrev <= refClkIn;
      if (refRise)
        divCnt <= divCnt + 2'h1;
    end
  end

  // count, cleared only by reset
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      cnt <= RST_WORD;
    else if (tick)
      cnt <= cntNext;
  end

  // registered view: upper byte hidden in the 24-bit option
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      count    <= RST_WORD;
      msbEvent <= 1'b0;
    end
    else
    begin
      count    <= cfgTimer32 ? cnt : {8'h00, cnt[23:0]};
      msbEvent <= msbFlip;
    end
  end

endmodule

// [logic/apmio_top.sv]
// power management i/o register block with sleep sequencing, processor
// stop-clock control, resume supply control and SCI / SMI routing.
// assumes all board inputs are synchronous to clk; host cycles are one-cycle
// strobes carried in ioReq.
`timescale 1ns/10ps
module apmio_top
  import apmio_pkg::*;
#(
  parameter int unsigned OVERRIDE_CYCLES  = OVERRIDE_CYC,
  parameter int unsigned SLOW_TICK_CYCLES = THR_SLOW_CYC
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // host i/o cycles
  input  wire apmio_req_s  ioReq,
  output logic [31:0]      ioRdData,
  output logic             ioRdValid,
  // board events
  input  wire logic        refClkIn,
  input  wire logic        powerButtonIn,
  input  wire logic        busMasterReqIn,
  input  wire logic        alarmEventIn,
  input  wire logic        globalEventIn,
  input  wire logic        ringIn,
  input  wire logic        serialBusEventIn,
  input  wire logic [7:0]  extEventIn,
  // configuration straps
  input  wire logic        cfgTimer32,
  input  wire logic        cfgThrottleSlow,
  // system outputs
  output logic             sciOut,
  output logic             smiOut,
  output logic             stopClockOut,
  output logic             supplyOnOut
);

  // ---------------- reset release ----------------
  logic rstMeta;   // first stage, read only by rstN
  logic rstN;      // released reset for the whole block

  // two-stage release so deassertion is clean on clk
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // ---------------- state ----------------
  logic [15:0]  pmSts;       // event status, write-one-clear
  logic [15:0]  pmEn;        // event enables
  logic [15:0]  pmCtl;       // sleep kind, release, busmaster_wake, select
  logic [31:0]  cpuCtl;      // throttle enable and duty
  logic [15:0]  gpSts;       // general status, write-one-clear
  logic [15:0]  gpSciEn;     // general SCI enables
  logic [15:0]  gpSmiEn;     // general SMI enables
  logic [15:0]  supplyCtl;   // resume supply controls
  logic [15:0]  glbSts;      // firmware flag
  logic [15:0]  glbEn;       // firmware enable
  apmio_sleep_e sleepSt;     // system sleep state
  apmio_cpu_e   cpuSt;       // processor clock state
  logic [31:0]  btnCnt;      // button held time
  logic [15:0]  evPrev;      // last level of event inputs
  logic [9:0]   gpPrev;      // last level of general inputs
  logic [31:0]  tickCnt;     // throttle time base divider
  logic [3:0]   slot;        // throttle slot within a period
  logic [31:0]  tmrCount;    // timer view from the counter
  logic         tmrMsb;      // timer top bit changed

  // ---------------- host decode ----------------
  wire [5:0]  wordIdx = ioReq.addr[7:2];
  wire [31:0] laneMask = {{8{ioReq.be[3]}}, {8{ioReq.be[2]}},
                          {8{ioReq.be[1]}}, {8{ioReq.be[0]}}};
  wire [31:0] wd      = ioReq.data & laneMask;
  wire selPm   = wordIdx == OFS_PM_STATUS[7:2];
  wire selCtl  = wordIdx == OFS_PM_CONTROL[7:2];
  wire selTmr  = wordIdx == OFS_TIMER[7:2];
  wire selCpu  = wordIdx == OFS_CPU_CTL[7:2];
  wire selLvl  = wordIdx == OFS_LEVEL2[7:2];
  wire selGp   = wordIdx == OFS_GP_STATUS[7:2];
  wire selGpEn = wordIdx == OFS_GP_SMI_EN[7:2];
  wire selGlb  = wordIdx == OFS_GLB_STATUS[7:2];
  wire wrPm    = ioReq.wr & selPm;
  wire wrCtl   = ioReq.wr & selCtl;
  wire wrCpu   = ioReq.wr & selCpu;
  wire wrGp    = ioReq.wr & selGp;
  wire wrGpEn  = ioReq.wr & selGpEn;
  wire wrGlb   = ioReq.wr & selGlb;
  // the level ports act only on reads; writes to them fall through
  wire rdLvl2  = ioReq.rd & selLvl & ioReq.be[OFS_LEVEL2[1:0]];
  wire rdLvl3  = ioReq.rd & selLvl & ioReq.be[OFS_LEVEL3[1:0]];

  // merge written lanes into a half, reserved bits forced low
  function automatic logic [15:0] rwHalf(input logic [15:0] old,
                                         input logic [15:0] nv,
                                         input logic [15:0] lanes,
                                         input logic [15:0] keep);
    rwHalf = ((old & ~lanes) | (nv & lanes)) & keep;
  endfunction

  // ---------------- event edges ----------------
  wire [15:0] evNow = {8'h00, 1'b0, globalEventIn, busMasterReqIn,
                       alarmEventIn, powerButtonIn, 3'h0};
  wire [15:0] evRise  = evNow & ~evPrev;
  wire pressRise  = evRise[3];
  wire alarmRise  = evRise[4];
  wire bmRise     = evRise[5];
  wire globalRise = evRise[6];
  wire [9:0] gpNow  = {serialBusEventIn, ringIn, extEventIn};
  wire [9:0] gpRise = gpNow & ~gpPrev;

  // ---------------- button override ----------------
  wire btnDone = btnCnt >= OVERRIDE_CYCLES;
  wire ovrHit  = powerButtonIn & (btnCnt == OVERRIDE_CYCLES - 1);

  // ---------------- resume and sleep ----------------
  wire asleep   = sleepSt != SLP_WORK;
  wire resumeEv = (pressRise    & supplyCtl[BTN_CTL_BIT])
                | (gpRise[RING_BIT] & supplyCtl[RING_CTL_BIT])
                | (alarmRise    & supplyCtl[ALM_CTL_BIT])
                | (gpRise[0]    & supplyCtl[EXT0_CTL_BIT]);
  wire wakeHit  = asleep & resumeEv;
  // sleep_go is never stored; its write pulse starts the sequence
  wire [15:0] ctlWr = rwHalf(pmCtl, wd[15:0], laneMask[15:0], MASK_PM_CTL);
  wire sleepGo  = wrCtl & wd[SLEEP_GO_BIT];
  wire [2:0] goKind = ctlWr[KIND_LSB+2:KIND_LSB];

  // ---------------- status set and clear ----------------
  wire [15:0] pmClr = wrPm ? wd[15:0] : RST_HALF;
  wire [15:0] pmSet = ({15'h0, tmrMsb} << TIMER_BIT)
                    | ({15'h0, bmRise} << BUSM_BIT)
                    | ({15'h0, globalRise} << GLOBAL_BIT)
                    | ({15'h0, pressRise} << PRESS_BIT)
                    | ({15'h0, alarmRise} << ALARM_BIT)
                    | ({15'h0, ovrHit} << OVR_BIT)
                    | ({15'h0, wakeHit} << WAKE_BIT);
  // set wins over a clear in the same cycle; override drops the press
  wire [15:0] next_pmSts = (((pmSts & ~pmClr) | pmSet) & MASK_PM_STATUS)
                         & ~({15'h0, ovrHit} << PRESS_BIT);
  wire [15:0] gpClr = wrGp ? wd[15:0] : RST_HALF;
  wire [15:0] next_gpSts = ((gpSts & ~gpClr) | {6'h00, gpRise})
                         & MASK_GP_STATUS;

  // release edge sets the firmware flag; clearing the flag drops release
  wire grelSet = wrCtl & ctlWr[GREL_BIT] & ~pmCtl[GREL_BIT];
  wire fwClr   = wrGlb & wd[FW_BIT] & glbSts[FW_BIT];
  wire [15:0] next_glbSts = ((glbSts & ~(wrGlb ? wd[15:0] : RST_HALF))
                          | ({15'h0, grelSet} << FW_BIT)) & MASK_GLB;
  wire [15:0] next_pmCtl = (wrCtl ? ctlWr : pmCtl)
                         & ~({15'h0, fwClr & ~grelSet} << GREL_BIT);

  // ---------------- interrupt routing ----------------
  wire [15:0] pmHit = pmSts & pmEn;
  wire timerIrq  = pmHit[TIMER_BIT];
  wire globalIrq = pmHit[GLOBAL_BIT];
  wire routedIrq = |(pmHit & MASK_ROUTED);
  wire useSci    = pmCtl[SELECT_BIT];
  wire fwIrq     = glbSts[FW_BIT] & glbEn[FW_BIT];
  wire gpSmiIrq  = |(gpSts & gpSmiEn);
  wire gpSciIrq  = |(gpSts & gpSciEn);
  // timer and global are SCI only, firmware SMI only, whatever the select
  wire next_sci  = timerIrq | globalIrq | gpSciIrq
                 | (routedIrq & useSci);
  wire next_smi  = fwIrq | gpSmiIrq | (routedIrq & ~useSci);
  wire irqRise   = (next_sci & ~sciOut) | (next_smi & ~smiOut);

  // ---------------- throttle modulation ----------------
  wire [31:0] tickLast = cfgThrottleSlow ? SLOW_TICK_CYCLES - 1
                                         : THR_FAST_CYC - 1;
  wire tickEn   = tickCnt >= tickLast;
  wire [2:0] duty = cpuCtl[DUTY_LSB+2:DUTY_LSB];
  // 16 slots a period; each duty step is two slots less one, so code n
  // lands inside its 12.5% band. code 000 never stops the clock.
  wire [4:0] onSlots = {duty, 1'b0} - 5'h01;
  wire modOn    = (duty != 3'h0) & ({1'b0, slot} < onSlots);
  wire next_stp = (cpuSt == CPU_C3)
                | ((cpuSt == CPU_C2) &
                   (cpuCtl[THR_EN_BIT] ? modOn : 1'b1));

  // ---------------- read mux ----------------
  logic [31:0] rdMux;
  always_comb
  begin
    unique case (1'b1)
      selPm:   rdMux = {pmEn, pmSts};
      selCtl:  rdMux = {RST_HALF, pmCtl};
      selTmr:  rdMux = tmrCount;
      selCpu:  rdMux = cpuCtl;
      selGp:   rdMux = {gpSciEn, gpSts};
      selGpEn: rdMux = {supplyCtl, gpSmiEn};
      selGlb:  rdMux = {glbEn, glbSts};
      default: rdMux = RST_WORD;   // level ports and holes read zero
    endcase
  end

  // ---------------- timer ----------------
  apmio_timer u_timer (
    .clk        (clk),
    .rstN       (rstN),
    .refClkIn   (refClkIn),
    .run        (sleepSt == SLP_WORK),
    .cfgTimer32 (cfgTimer32),
    .count      (tmrCount),
    .msbEvent   (tmrMsb)
  );

  // event registers and edge history
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pmSts  <= RST_HALF;
      gpSts  <= RST_HALF;
      glbSts <= RST_HALF;
      pmCtl  <= RST_HALF;
      evPrev <= RST_HALF;
      gpPrev <= 10'h000;
    end
    else
    begin
      pmSts  <= next_pmSts;
      gpSts  <= next_gpSts;
      glbSts <= next_glbSts;
      pmCtl  <= next_pmCtl;
      evPrev <= evNow;
      gpPrev <= gpNow;
    end
  end

  // plain read-write enables and controls
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pmEn      <= RST_HALF;
      cpuCtl    <= RST_WORD;
      gpSciEn   <= RST_HALF;
      gpSmiEn   <= RST_HALF;
      supplyCtl <= RST_HALF;
      glbEn     <= RST_HALF;
    end
    else
    begin
      if (wrPm)
        pmEn <= rwHalf(pmEn, wd[31:16], laneMask[31:16], MASK_PM_ENABLE);
      if (wrCpu)
        cpuCtl <= ((cpuCtl & ~laneMask) | wd) & MASK_CPU_CTL;
      if (wrGp)
        gpSciEn <= rwHalf(gpSciEn, wd[31:16], laneMask[31:16], MASK_GP_SCI);
      if (wrGpEn)
      begin
        gpSmiEn   <= rwHalf(gpSmiEn, wd[15:0], laneMask[15:0], MASK_GP_SMI);
        supplyCtl <= rwHalf(supplyCtl, wd[31:16], laneMask[31:16],
                            MASK_SUPPLY);
      end
      if (wrGlb)
        glbEn <= rwHalf(glbEn, wd[31:16], laneMask[31:16], MASK_GLB);
    end
  end

  // button hold counter, restarts on any release
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      btnCnt <= RST_WORD;
    else if (!powerButtonIn)
      btnCnt <= RST_WORD;
    else if (!btnDone)
      btnCnt <= btnCnt + 32'h1;
  end

  // system sleep sequencing; override beats everything
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      sleepSt <= SLP_WORK;
    else if (ovrHit)
      sleepSt <= SLP_OFF;
    else
    begin
      unique case (sleepSt)
        SLP_WORK:
          if (sleepGo && goKind == KIND_SOFT_OFF)
            sleepSt <= SLP_OFF;
          else if (sleepGo && goKind == KIND_SUSPEND)
            sleepSt <= SLP_SUSP;
        SLP_OFF, SLP_SUSP:
          if (wakeHit)
            sleepSt <= SLP_WORK;
        default:
          sleepSt <= SLP_WORK;
      endcase
    end
  end

  // processor clock state
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      cpuSt <= CPU_C0;
    else
    begin
      unique case (cpuSt)
        CPU_C0:
          if (rdLvl3 || (sleepGo && goKind == KIND_SUSPEND))
            cpuSt <= CPU_C3;
          else if (rdLvl2)
            cpuSt <= CPU_C2;
        // any new interrupt or bus master request ends C2
        CPU_C2:
          if (irqRise || bmRise)
            cpuSt <= CPU_C0;
        // bus masters only wake C3 when allowed
        CPU_C3:
          if (wakeHit || (bmRise && pmCtl[BMWAKE_BIT]))
            cpuSt <= CPU_C0;
        default:
          cpuSt <= CPU_C0;
      endcase
    end
  end

  // throttle time base and slot counter
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      tickCnt <= RST_WORD;
      slot    <= 4'h0;
    end
    else if (tickEn)
    begin
      tickCnt <= RST_WORD;
      slot    <= slot + 4'h1;
    end
    else
      tickCnt <= tickCnt + 32'h1;
  end

  // registered outputs; soft off drops the main supply
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ioRdData     <= RST_WORD;
      ioRdValid    <= 1'b0;
      sciOut       <= 1'b0;
      smiOut       <= 1'b0;
      stopClockOut <= 1'b0;
      supplyOnOut  <= 1'b1;
    end
    else
    begin
      ioRdData     <= ioReq.rd ? rdMux : RST_WORD;
      ioRdValid    <= ioReq.rd;
      sciOut       <= next_sci;
      smiOut       <= next_smi;
      stopClockOut <= next_stp;
      supplyOnOut  <= sleepSt != SLP_OFF;
    end
  end

endmodule
